// ==== inc/cbu_map.svh ====
// Purpose: Constants of the conditional branch unit
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef CBU_MAP_SVH
`define CBU_MAP_SVH

`define CBU_PC_STEP 16'h0002
`define CBU_OFF_STEP 16'h0001
`define CBU_DUMMY_ADDR 16'hffff
`define CBU_FAMILY 4'h2
`define CBU_OPC_ALWAYS 8'h20
`define CBU_OPC_NEVER 8'h21
`define CBU_OPC_ULE 8'h23
`define CBU_OPC_SLT 8'h2d
`define CBU_FLAGS_RST 4'h0

`endif

// ==== inc/cbu_pkg.sv ====
// Purpose: Types of the conditional branch unit
// Assumes: Nothing
// Notes: Constants live in cbu_map.svh
package cbu_pkg;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } cbu_flags_t;

   typedef enum logic [3:0] {
      CBU_OP_CMP, CBU_OP_SUB, CBU_OP_INC, CBU_OP_DEC, CBU_OP_LOAD,
      CBU_OP_STORE, CBU_OP_TEST, CBU_OP_CLEAR, CBU_OP_COM
   } cbu_alu_op_t;

   typedef enum logic [1:0] {
      CBU_IDLE, CBU_FETCH_OP, CBU_FETCH_OFF, CBU_DUMMY
   } cbu_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic read;
      logic cycle;
   } cbu_bus_t;

   typedef struct packed {
      cbu_state_t state;
      cbu_bus_t bus;
      logic [15:0] opAddr;
      logic [7:0] opcode;
      logic [7:0] offset;
      logic taken;
      logic busy;
      logic [15:0] pcOut;
      logic pcLoad;
      cbu_flags_t flags;
   } cbu_regs_t;

endpackage : cbu_pkg

// ==== src/cbu_flag_unit.sv ====
// Purpose: Next condition flags for compare, subtract and simple ops
// Assumes: Operands are 8-bit accumulator and memory values
// Notes: Purely combinational; the caller owns the flag register
`timescale 1ns/100ps
`default_nettype none

module cbu_flag_unit (
   input wire cbu_pkg::cbu_alu_op_t op,
   input wire logic [7:0] accum,
   input wire logic [7:0] operand,
   input wire cbu_pkg::cbu_flags_t flagsIn,
   output cbu_pkg::cbu_flags_t flagsOut
);

   logic [8:0] diff;
   logic [7:0] res;

   // Flag update per operation
   always_comb
   begin
      diff = {1'b0, accum} - {1'b0, operand};
      res = accum;
      flagsOut = flagsIn;
      unique case (op)
         cbu_pkg::CBU_OP_CMP, cbu_pkg::CBU_OP_SUB:
         begin
            res = diff[7:0];
            flagsOut.c = diff[8]; // Borrow means unsigned lower
            flagsOut.v = (accum[7] & ~operand[7] & ~res[7]) |
                         (~accum[7] & operand[7] & res[7]);
         end
         cbu_pkg::CBU_OP_INC:
         begin
            res = accum + 8'h01;
            flagsOut.v = (accum == 8'h7f);
         end
         cbu_pkg::CBU_OP_DEC:
         begin
            res = accum - 8'h01;
            flagsOut.v = (accum == 8'h80);
         end
         cbu_pkg::CBU_OP_CLEAR:
         begin
            res = 8'h00;
            flagsOut.v = 1'b0;
         end
         cbu_pkg::CBU_OP_COM:
         begin
            res = ~accum;
            flagsOut.v = 1'b0;
         end
         // Load, store and test pass the value through
         cbu_pkg::CBU_OP_LOAD, cbu_pkg::CBU_OP_STORE, cbu_pkg::CBU_OP_TEST:
         begin
            res = accum;
            flagsOut.v = 1'b0;
         end
      endcase
      flagsOut.n = res[7];
      flagsOut.z = (res == 8'h00);
   end

endmodule : cbu_flag_unit
`default_nettype wire

// ==== src/cbu_branch_unit.sv ====
// Purpose: Relative conditional branch sequencer and flag register
// Assumes: Read data is valid in the cycle its address is shown
// Notes: Overview below; flags change only while idle
//
// Overview of operation
// - Taken: PC = opcode address+2+offset
// - Opcode 23 taken when C or Z
// - After compare: unsigned less-or-equal branches
// - Opcode 2D taken when N xor V
// - After compare: signed less-than branches
// - Branches never change the flags
// - Three reads: opcode, offset, dummy FFFF
// - Simple ops leave carry unchanged
// - Compares and subtracts set all flags
`timescale 1ns/100ps
`default_nettype none
`include "cbu_map.svh"

module cbu_branch_unit (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic branchGo,
   input wire logic [15:0] branchPc,
   input wire logic [7:0] busData,
   input wire logic aluGo,
   input wire cbu_pkg::cbu_alu_op_t aluOp,
   input wire logic [7:0] aluAccum,
   input wire logic [7:0] aluOperand,
   output logic [15:0] busAddr,
   output logic busRead,
   output logic busCycle,
   output logic [15:0] pcOut,
   output logic pcLoad,
   output logic branchTaken,
   output logic busy,
   output cbu_pkg::cbu_flags_t flags
);

   cbu_pkg::cbu_regs_t r;
   cbu_pkg::cbu_regs_t next_r;
   cbu_pkg::cbu_flags_t aluFlags;
   logic [15:0] offsetExt;

   // Flag arithmetic shared with the rest of the core
   cbu_flag_unit u_flags (
      .op(aluOp),
      .accum(aluAccum),
      .operand(aluOperand),
      .flagsIn(r.flags),
      .flagsOut(aluFlags)
   );

   // Condition of any opcode in the family
   function automatic logic condHolds(input logic [7:0] opc, input cbu_pkg::cbu_flags_t f);
      logic base;
      base = 1'b0;
      unique case (opc[3:1])
         3'h0: base = 1'b1;
         3'h1: base = ~(f.c | f.z);
         3'h2: base = ~f.c;
         3'h3: base = ~f.z;
         3'h4: base = ~f.v;
         3'h5: base = ~f.n;
         3'h6: base = ~(f.n ^ f.v);
         3'h7: base = ~(f.z | (f.n ^ f.v));
      endcase
      return (opc[7:4] == `CBU_FAMILY) & (base ^ opc[0]);
   endfunction : condHolds

   assign offsetExt = {{8{r.offset[7]}}, r.offset};

   // Sequencer next state
   always_comb
   begin
      next_r = r;
      next_r.pcLoad = 1'b0;
      unique case (r.state)
         cbu_pkg::CBU_IDLE:
         begin
            if (branchGo)
            begin
               next_r.opAddr = branchPc;
               next_r.bus.addr = branchPc;
               next_r.bus.read = 1'b1;
               next_r.bus.cycle = 1'b1;
               next_r.busy = 1'b1;
               next_r.state = cbu_pkg::CBU_FETCH_OP;
            end
            else if (aluGo)
            begin
               next_r.flags = aluFlags;
            end
         end
         cbu_pkg::CBU_FETCH_OP:
         begin
            next_r.opcode = busData;
            next_r.bus.addr = r.opAddr + `CBU_OFF_STEP;
            next_r.state = cbu_pkg::CBU_FETCH_OFF;
         end
         cbu_pkg::CBU_FETCH_OFF:
         begin
            next_r.offset = busData;
            next_r.taken = condHolds(r.opcode, r.flags);
            next_r.bus.addr = `CBU_DUMMY_ADDR;
            next_r.state = cbu_pkg::CBU_DUMMY;
         end
         cbu_pkg::CBU_DUMMY:
         begin
            next_r.pcOut = r.taken ? r.opAddr + `CBU_PC_STEP + offsetExt
                                   : r.opAddr + `CBU_PC_STEP;
            next_r.pcLoad = 1'b1;
            next_r.bus.cycle = 1'b0;
            next_r.bus.read = 1'b0;
            next_r.busy = 1'b0;
            next_r.state = cbu_pkg::CBU_IDLE;
         end
      endcase
   end

   // State register; flags untouched while busy
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         r <= '0;
         r.state <= cbu_pkg::CBU_IDLE;
         r.flags <= `CBU_FLAGS_RST;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign busAddr = r.bus.addr;
   assign busRead = r.bus.read;
   assign busCycle = r.bus.cycle;
   assign pcOut = r.pcOut;
   assign pcLoad = r.pcLoad;
   assign branchTaken = r.taken;
   assign busy = r.busy;
   assign flags = r.flags;

   // Checker helpers: operands of the last flag-setting op
   logic cmpValid;
   logic [7:0] cmpA;
   logic [7:0] cmpB;
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         cmpValid <= 1'b0;
         cmpA <= 8'h00;
         cmpB <= 8'h00;
      end
      else if (aluGo && !branchGo && r.state == cbu_pkg::CBU_IDLE)
      begin
         cmpValid <= (aluOp == cbu_pkg::CBU_OP_CMP) || (aluOp == cbu_pkg::CBU_OP_SUB);
         cmpA <= aluAccum;
         cmpB <= aluOperand;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   property p_target_taken;
      pcLoad && branchTaken |-> pcOut == 16'(r.opAddr + 16'h0002 + {{8{r.offset[7]}}, r.offset});
   endproperty
   a_target_taken: assert property (p_target_taken) else $error("bad taken target");

   property p_target_fall;
      pcLoad && !branchTaken |-> pcOut == 16'(r.opAddr + 16'h0002);
   endproperty
   a_target_fall: assert property (p_target_fall) else $error("bad fall-through pc");

   property p_ule_cond;
      pcLoad && r.opcode == 8'h23 |-> branchTaken == (flags.c | flags.z);
   endproperty
   a_ule_cond: assert property (p_ule_cond) else $error("ule test wrong");

   property p_ule_relation;
      pcLoad && r.opcode == 8'h23 && cmpValid |-> branchTaken == (cmpA <= cmpB);
   endproperty
   a_ule_relation: assert property (p_ule_relation) else $error("ule relation wrong");

   property p_slt_cond;
      pcLoad && r.opcode == 8'h2d |-> branchTaken == (flags.n ^ flags.v);
   endproperty
   a_slt_cond: assert property (p_slt_cond) else $error("slt test wrong");

   property p_slt_relation;
      pcLoad && r.opcode == 8'h2d && cmpValid |-> branchTaken == ($signed(cmpA) < $signed(cmpB));
   endproperty
   a_slt_relation: assert property (p_slt_relation) else $error("slt relation wrong");

   property p_flags_hold;
      busy |=> $stable(flags);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags moved in branch");

   sequence s_op(logic [15:0] a);
      busCycle && busRead && busAddr == a;
   endsequence
   sequence s_dummy;
      busCycle && busRead && busAddr == 16'hffff;
   endsequence
   property p_bus_seq;
      logic [15:0] a;
      (branchGo && !busy, a = branchPc) |=>
         s_op(a) ##1 s_op(16'(a + 16'h0001)) ##1 s_dummy ##1 (!busCycle && pcLoad);
   endproperty
   a_bus_seq: assert property (p_bus_seq) else $error("bus cycle sequence wrong");

   property p_carry_kept;
      aluGo && !branchGo && !busy && aluOp != cbu_pkg::CBU_OP_CMP &&
         aluOp != cbu_pkg::CBU_OP_SUB |=> $stable(flags.c);
   endproperty
   a_carry_kept: assert property (p_carry_kept) else $error("carry changed");

   property p_cmp_zero;
      aluGo && !branchGo && !busy && aluOp == cbu_pkg::CBU_OP_CMP |=>
         flags.z == ($past(aluAccum) == $past(aluOperand)) &&
         flags.c == ($past(aluAccum) < $past(aluOperand));
   endproperty
   a_cmp_zero: assert property (p_cmp_zero) else $error("compare flags wrong");

   property p_family;
      pcLoad |-> ((r.opcode[7:4] != 4'h2) ? !branchTaken
         : (r.opcode[3:1] != 3'h0 || branchTaken == !r.opcode[0]));
   endproperty
   a_family: assert property (p_family) else $error("always/never wrong");

endmodule : cbu_branch_unit
`default_nettype wire

// ==== verification/cbu_prog_mem.sv ====
// Purpose: Program memory model answering the branch unit's reads
// Assumes: Read data must be valid in the cycle the address is shown
// Notes: Outside its two bytes it shows the inverse of the last value
`timescale 1ns/100ps
`default_nettype none

module cbu_prog_mem (
   input wire logic mclk,
   input wire logic [15:0] busAddr,
   input wire logic busCycle,
   input wire logic [15:0] baseAddr,
   input wire logic [7:0] opByte,
   input wire logic [7:0] offByte,
   output logic [7:0] busData
);
   logic [7:0] lastData = 8'h00;

   // opcode then offset
   // Dummy read gets junk so a design using it is caught
   always_comb
   begin
      if (busCycle && busAddr == baseAddr)
         busData = opByte;
      else if (busCycle && busAddr == baseAddr + 16'h0001)
         busData = offByte;
      else
         busData = ~lastData;
   end

   // Remember last value for the junk pattern
   always @(posedge mclk)
   begin
      lastData <= busData;
   end
endmodule : cbu_prog_mem
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: Self-checking bench of the conditional branch unit
// Assumes: Inputs change at the falling edge of mclk
// Notes: Compares set flags, then every family opcode is run
`timescale 1ns/100ps
`default_nettype none
`include "cbu_map.svh"

module tb;
   logic mclk = 1'b0, nrst = 1'b0, branchGo = 1'b0, aluGo = 1'b0;
   logic [15:0] branchPc = 16'h0000, baseAddr = 16'h0000;
   logic [7:0] busData, opByte = 8'h00, offByte = 8'h00;
   logic [7:0] aluAccum = 8'h00, aluOperand = 8'h00;
   cbu_pkg::cbu_alu_op_t aluOp = cbu_pkg::CBU_OP_CMP;
   logic [15:0] busAddr, pcOut;
   logic busRead, busCycle, pcLoad, branchTaken, busy;
   cbu_pkg::cbu_flags_t flags;
   int num_errors = 0, num_checks = 0, cycles = 0;
   logic [7:0] accT [5] = '{8'h05, 8'h03, 8'h80, 8'h7f, 8'h00};
   logic [7:0] memT [5] = '{8'h05, 8'h80, 8'h03, 8'hff, 8'h01};

   cbu_branch_unit dut_u (.mclk(mclk), .nrst(nrst), .branchGo(branchGo),
      .branchPc(branchPc), .busData(busData), .aluGo(aluGo), .aluOp(aluOp),
      .aluAccum(aluAccum), .aluOperand(aluOperand), .busAddr(busAddr),
      .busRead(busRead), .busCycle(busCycle), .pcOut(pcOut), .pcLoad(pcLoad),
      .branchTaken(branchTaken), .busy(busy), .flags(flags));
   cbu_prog_mem mem_u (.mclk(mclk), .busAddr(busAddr), .busCycle(busCycle),
      .baseAddr(baseAddr), .opByte(opByte), .offByte(offByte), .busData(busData));

   // Clock at 200 MHz
   initial
   begin
      forever #2.5 mclk = ~mclk;
   end

   // Hang guard, well above the planned run
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         complete_run();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run

   // Flags {n,z,v,c} of acc minus operand
   function automatic logic [3:0] cmp_flags(input logic [7:0] a, input logic [7:0] m);
      logic [7:0] r;
      r = a - m;
      return {r[7], r == 8'h00, (a[7] ^ m[7]) & (a[7] ^ r[7]), a < m};
   endfunction : cmp_flags

   // Branch outcome; 23 and 2D judged from the operands themselves
   function automatic logic exp_taken(input logic [7:0] opc, input logic [7:0] a,
      input logic [7:0] m);
      logic n, z, v, c, t;
      {n, z, v, c} = cmp_flags(a, m);
      case (opc[3:1])
         3'h0: t = 1'b1;
         3'h1: t = !(c | z);
         3'h2: t = !c;
         3'h3: t = !z;
         3'h4: t = !v;
         3'h5: t = !n;
         3'h6: t = !(n ^ v);
         default: t = !(z | (n ^ v));
      endcase
      t = opc[0] ? !t : t;
      if (opc == `CBU_OPC_ULE)
         t = a <= m;
      if (opc == `CBU_OPC_SLT)
         t = $signed(a) < $signed(m);
      return (opc[7:4] == `CBU_FAMILY) ? t : 1'b0;
   endfunction : exp_taken

   task automatic alu(input cbu_pkg::cbu_alu_op_t op, input logic [7:0] a, input logic [7:0] m);
      @(negedge mclk);
      aluGo = 1'b1;
      aluOp = op;
      aluAccum = a;
      aluOperand = m;
      @(negedge mclk);
      aluGo = 1'b0;
   endtask : alu

   // One branch, walked cycle by cycle against the memory model
   task automatic run_branch(input logic [15:0] pc, input logic [7:0] opc,
      input logic [7:0] off, input logic expT);
      logic [15:0] tgt;
      logic [3:0] f0;
      tgt = pc + `CBU_PC_STEP + (expT ? {{8{off[7]}}, off} : 16'h0000);
      f0 = flags;
      @(negedge mclk);
      {baseAddr, opByte, offByte, branchPc, branchGo} = {pc, opc, off, pc, 1'b1};
      @(negedge mclk);
      branchGo = 1'b0;
      check("opcode read", {busAddr, busRead, busCycle, busy}, {pc, 3'b111});
      @(negedge mclk);
      check("offset read", {busAddr, busRead, busCycle}, {pc + `CBU_OFF_STEP, 2'b11});
      @(negedge mclk);
      check("dummy read", {busAddr, busRead, busCycle}, {`CBU_DUMMY_ADDR, 2'b11});
      @(negedge mclk);
      check("load", {pcLoad, busCycle, branchTaken}, {2'b10, expT});
      check("target", pcOut, tgt);
      check("flags kept", {12'h000, flags}, {12'h000, f0});
   endtask : run_branch

   // Compares and subtracts, then every family opcode after each
   task automatic scen_family();
      for (int p = 0; p < 5; p++)
      begin
         alu(p[0] ? cbu_pkg::CBU_OP_SUB : cbu_pkg::CBU_OP_CMP, accT[p], memT[p]);
         check("cmp flags", {12'h000, flags}, {12'h000, cmp_flags(accT[p], memT[p])});
         for (int o = 0; o < 16; o++)
            run_branch(16'(16'h2000 + p * 256 + o), 8'(8'h20 + o), o[0] ? 8'h80 : 8'h7f,
               exp_taken(8'(8'h20 + o), accT[p], memT[p]));
      end
      run_branch(16'hfffe, 8'h30, 8'h10, 1'b0);
   endtask : scen_family

   // Carry survives the simple ops, both carry values
   task automatic scen_carry();
      for (int s = 0; s < 2; s++)
      begin
         alu(cbu_pkg::CBU_OP_CMP, 8'(s), 8'(1 - s));
         for (int k = 2; k < 9; k++)
         begin
            alu(cbu_pkg::cbu_alu_op_t'(k), 8'h40, 8'h41);
            check("carry", {15'h0000, flags.c}, {15'h0000, s == 0});
         end
      end
   endtask : scen_carry

   // Requests while busy are refused; a new branch may start at pcLoad
   task automatic scen_refused();
      logic [3:0] f0;
      f0 = flags;
      @(negedge mclk);
      {baseAddr, opByte, offByte} = {16'h4000, 8'h20, 8'h10};
      {branchPc, branchGo} = {16'h4000, 1'b1};
      @(negedge mclk);
      branchPc = 16'h5000;
      aluGo = 1'b1;
      aluOp = cbu_pkg::CBU_OP_CMP;
      aluAccum = 8'h00;
      aluOperand = 8'h00;
      check("busy opcode read", {busAddr, busy}, {16'h4000, 1'b1});
      @(negedge mclk);
      branchGo = 1'b0;
      aluGo = 1'b0;
      check("busy offset read", busAddr, 16'h4001);
      @(negedge mclk);
      check("busy dummy read", busAddr, `CBU_DUMMY_ADDR);
      @(negedge mclk);
      check("first load", {pcLoad, branchTaken, pcOut}, {2'b11, 16'h4012});
      check("refused alu", {28'h0000000, flags}, {28'h0000000, f0});
      // Next branch and a clashing flag update in the pcLoad cycle
      {baseAddr, opByte, offByte} = {16'h6000, 8'h21, 8'h05};
      {branchPc, branchGo, aluGo} = {16'h6000, 2'b11};
      @(negedge mclk);
      branchGo = 1'b0;
      aluGo = 1'b0;
      check("back to back", {busAddr, busy}, {16'h6000, 1'b1});
      repeat (3) @(negedge mclk);
      check("second load", {pcLoad, branchTaken, pcOut}, {2'b10, 16'h6002});
      check("alu with branch", {28'h0000000, flags}, {28'h0000000, f0});
   endtask : scen_refused

   // Reset in mid-branch returns to idle; a branch then runs normally
   task automatic scen_reset();
      @(negedge mclk);
      {baseAddr, opByte, offByte} = {16'h7000, 8'h20, 8'h10};
      {branchPc, branchGo} = {16'h7000, 1'b1};
      @(negedge mclk);
      branchGo = 1'b0;
      nrst = 1'b0;
      repeat (2) @(negedge mclk);
      check("mid reset", {busCycle, busRead, pcLoad, busy, branchTaken, flags, pcOut},
         {5'h00, `CBU_FLAGS_RST, 16'h0000});
      nrst = 1'b1;
      // Reset flags clear carry, so the carry-clear branch is taken
      run_branch(16'h7100, 8'h24, 8'h04, 1'b1);
   endtask : scen_reset

   // Main sequence
   initial
   begin
      repeat (10) @(negedge mclk);
      nrst = 1'b1;
      check("reset", {busCycle, pcLoad, busy, flags}, {3'b000, `CBU_FLAGS_RST});
      scen_family();
      scen_carry();
      scen_refused();
      scen_reset();
      complete_run();
   end
endmodule : tb
`default_nettype wire
